// ===== rtl/pdcs_pkg.sv
// Purpose: constants for the per-port device control and status bank
// Assumes: 16-bit registers on a plain strobe port, one clock
// Notes: status events are sticky, cleared by writing one
//
// Overview of operation
// - control bit 0 gates correctable reporting
// - control bit 1 gates non-fatal reporting
// - control bit 2 gates fatal reporting
// - control bit 3 gates unsupported request reporting
// - relaxed ordering bit 4 reads zero, never set
// - bits 7:5 payload size, codes 0-4
// - payload codes 5-7 act as 128 bytes
// - bit 8 extended tag, debug tag range
// - phantom function bit 9 reads zero
// - aux power enable bit 10 reads zero
// - no-snoop bit 11 zero, attribute forwarded unchanged
// - read request size reads zero, no effect
// - status bit 0 correctable seen, write-one clear
// - status bit 1 non-fatal seen, write-one clear
// - status bit 2 fatal seen, write-one clear
// - status bit 3 unsupported seen, write-one clear
// - status bit 4 aux power reads zero
// - status bit 5 pending reads zero
package pdcs_pkg;
  localparam logic [7:0] PDCS_DEV_CTL_OFF = 8'h48;
  localparam logic [7:0] PDCS_DEV_STS_OFF = 8'h4a;
  localparam logic [7:0] PDCS_IRQ_MASK_OFF = 8'h4c;
  localparam logic [7:0] PDCS_DBG_CTL_OFF = 8'h4e;
  localparam logic [15:0] PDCS_CTL_RESET = 16'h0000;
  localparam logic [15:0] PDCS_STS_RESET = 16'h0000;
  localparam logic [15:0] PDCS_MASK_RESET = 16'h0000;
  // writable control bits: enables 3:0, payload 7:5, ext tag 8
  localparam logic [15:0] PDCS_CTL_WMASK = 16'h01ef;
  localparam logic [15:0] PDCS_STS_WMASK = 16'h000f;
  localparam int PDCS_CE_BIT = 0;
  localparam int PDCS_NFE_BIT = 1;
  localparam int PDCS_FE_BIT = 2;
  localparam int PDCS_UR_BIT = 3;
  localparam int PDCS_MPS_LSB = 5;
  localparam int PDCS_ETAG_BIT = 8;
  localparam logic [2:0] PDCS_MPS_MAX_CODE = 3'h4;
  localparam logic [7:0] PDCS_TAG_MAX_SHORT = 8'h1f;
  localparam logic [7:0] PDCS_TAG_MAX_LONG = 8'hff;
  localparam logic [11:0] PDCS_MPS_128 = 12'h080;
endpackage : pdcs_pkg

// ===== rtl/pdcs_sticky.sv
// Purpose: one sticky event bit with write-one clear
// Assumes: event and clear are single-cycle qualified
// Notes: set wins over clear in the same cycle
`timescale 1ns/1ns
`default_nettype none
module pdcs_sticky (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic set_i,
  input wire logic clr_i,
  output logic flag_o
);
  logic flag_q;
  logic flag_d;
  assign flag_d = set_i | (flag_q & ~clr_i);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) flag_q <= 1'b0;
    else flag_q <= flag_d;
  end
  assign flag_o = flag_q;
endmodule : pdcs_sticky
`default_nettype wire

// ===== rtl/pdcs_tag_gen.sv
// Purpose: sequential debug tag counter
// Assumes: advance is sampled every clock; each cycle it is high is one step
// Notes: wraps at 31 or 255 by the extended tag enable
`timescale 1ns/1ns
`default_nettype none
module pdcs_tag_gen
  import pdcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable_i,
  input wire logic ext_tag_i,
  input wire logic advance_i,
  output logic [7:0] tag_o
);
  logic [7:0] tag_q;
  logic [7:0] tag_d;
  logic [7:0] tag_max;
  assign tag_max = ext_tag_i ? PDCS_TAG_MAX_LONG : PDCS_TAG_MAX_SHORT;
  // clearing the enable restarts at zero; shrinking range sends an out-of-range tag back to zero
  assign tag_d = !enable_i ? 8'h00 :
                 (tag_q >= tag_max) ? 8'h00 : 8'(tag_q + 8'h01);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tag_q <= 8'h00;
    // zero at once, without an advance, so a narrowed range does not keep a stale tag
    else if (advance_i || !enable_i || tag_q > tag_max) tag_q <= tag_d;
  end
  assign tag_o = tag_q;
endmodule : pdcs_tag_gen
`default_nettype wire

// ===== rtl/pdcs_top.sv
// Purpose: device control and device status registers of one port
// Assumes: software is the only party at the register port
// Notes: unmapped reads return zero, unmapped writes are dropped
//
// Added by the designer: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module pdcs_top
  import pdcs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic [7:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  input wire logic CORRECTABLE_ERR,
  input wire logic NONFATAL_ERR,
  input wire logic FATAL_ERR,
  input wire logic UNSUPPORTED_REQ,
  output logic REPORT_CORRECTABLE,
  output logic REPORT_NONFATAL,
  output logic REPORT_FATAL,
  output logic REPORT_UNSUPPORTED_REQ,
  output logic [11:0] MAX_PAYLOAD_BYTES,
  output logic RELAXED_ORDERING_CTL,
  output logic NO_SNOOP_ENABLE,
  input wire logic FWD_NO_SNOOP_IN,
  output logic FWD_NO_SNOOP_OUT,
  input wire logic [2:0] FWD_RD_REQ_SIZE_IN,
  output logic [2:0] FWD_RD_REQ_SIZE_OUT,
  input wire logic TAG_ADVANCE,
  output logic [7:0] DEBUG_TAG,
  output logic IRQ
);
  logic [15:0] ctl_q;
  logic [15:0] ctl_d;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic dbg_q;
  logic dbg_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [15:0] sts_val;
  logic [3:0] evt;
  logic [3:0] sts_bits;
  logic [11:0] payload_q;
  logic [11:0] payload_d;

  wire hit_ctl = REG_ADDR == PDCS_DEV_CTL_OFF;
  wire hit_sts = REG_ADDR == PDCS_DEV_STS_OFF;
  wire hit_mask = REG_ADDR == PDCS_IRQ_MASK_OFF;
  wire hit_dbg = REG_ADDR == PDCS_DBG_CTL_OFF;
  wire wr_ctl = REG_WR & hit_ctl;
  wire wr_sts = REG_WR & hit_sts;
  wire wr_mask = REG_WR & hit_mask;
  wire wr_dbg = REG_WR & hit_dbg;

  // read-only zero bits are never stored, so writes cannot reach them
  assign ctl_d = wr_ctl ? (REG_WDATA & PDCS_CTL_WMASK) : ctl_q;
  assign mask_d = wr_mask ? (REG_WDATA & PDCS_STS_WMASK) : mask_q;
  assign dbg_d = wr_dbg ? REG_WDATA[0] : dbg_q;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ctl_q <= PDCS_CTL_RESET;
      mask_q <= PDCS_MASK_RESET;
      dbg_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      mask_q <= mask_d;
      dbg_q <= dbg_d;
    end
  end

  // status events: logged whatever the reporting enables say
  assign evt = {UNSUPPORTED_REQ, FATAL_ERR, NONFATAL_ERR, CORRECTABLE_ERR};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sts
      pdcs_sticky u_sticky (
        .clk(REF_CLK),
        .rst_n(RESETN),
        .set_i(evt[g]),
        .clr_i(wr_sts & REG_WDATA[g]),
        .flag_o(sts_bits[g])
      );
    end
  endgenerate
  // aux power and pending bits and 15:6 are constant zero
  assign sts_val = {12'h000, sts_bits};

  // reporting gated by the enables
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      REPORT_CORRECTABLE <= 1'b0;
      REPORT_NONFATAL <= 1'b0;
      REPORT_FATAL <= 1'b0;
      REPORT_UNSUPPORTED_REQ <= 1'b0;
    end else begin
      REPORT_CORRECTABLE <= CORRECTABLE_ERR & ctl_q[PDCS_CE_BIT];
      REPORT_NONFATAL <= NONFATAL_ERR & ctl_q[PDCS_NFE_BIT];
      REPORT_FATAL <= FATAL_ERR & ctl_q[PDCS_FE_BIT];
      REPORT_UNSUPPORTED_REQ <= UNSUPPORTED_REQ & ctl_q[PDCS_UR_BIT];
    end
  end

  // payload decode; reserved codes fall back to the smallest size
  wire [2:0] mps_code = ctl_q[PDCS_MPS_LSB +: 3];
  assign payload_d = (mps_code > PDCS_MPS_MAX_CODE) ? PDCS_MPS_128 :
                     12'(PDCS_MPS_128 << mps_code);
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) payload_q <= PDCS_MPS_128;
    else payload_q <= payload_d;
  end
  assign MAX_PAYLOAD_BYTES = payload_q;

  // attributes the port would originate are fixed off
  assign RELAXED_ORDERING_CTL = 1'b0;
  assign NO_SNOOP_ENABLE = 1'b0;
  assign FWD_NO_SNOOP_OUT = FWD_NO_SNOOP_IN;
  assign FWD_RD_REQ_SIZE_OUT = FWD_RD_REQ_SIZE_IN;

  pdcs_tag_gen u_tag (
    .clk(REF_CLK),
    .rst_n(RESETN),
    .enable_i(dbg_q),
    .ext_tag_i(ctl_q[PDCS_ETAG_BIT]),
    .advance_i(TAG_ADVANCE),
    .tag_o(DEBUG_TAG)
  );

  // bits 4, 9..15 of control are zero in storage, read straight out
  assign rdata_d = !REG_RD ? 16'h0000 :
                   hit_ctl ? ctl_q :
                   hit_sts ? sts_val :
                   hit_mask ? mask_q :
                   hit_dbg ? {15'h0000, dbg_q} : 16'h0000;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) rdata_q <= 16'h0000;
    else rdata_q <= rdata_d;
  end
  assign REG_RDATA = rdata_q;

  assign IRQ = |(sts_val & mask_q);

  property p_ctl_ro_zero;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q & ~PDCS_CTL_WMASK) == 16'h0000;
  endproperty
  a_ctl_ro_zero: assert property (p_ctl_ro_zero)
    else $error("control read-only bits not zero");

  property p_ce_set;
    @(posedge REF_CLK) disable iff (!RESETN)
      CORRECTABLE_ERR |=> sts_bits[0];
  endproperty
  a_ce_set: assert property (p_ce_set)
    else $error("correctable event not logged");

  property p_nfe_clear;
    @(posedge REF_CLK) disable iff (!RESETN)
      (wr_sts && REG_WDATA[1] && !NONFATAL_ERR) |=> !sts_bits[1];
  endproperty
  a_nfe_clear: assert property (p_nfe_clear)
    else $error("non-fatal bit not cleared");

  property p_fe_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
      (sts_bits[2] && !(wr_sts && REG_WDATA[2])) |=> sts_bits[2];
  endproperty
  a_fe_hold: assert property (p_fe_hold)
    else $error("fatal bit lost without clear");

  property p_ur_set;
    @(posedge REF_CLK) disable iff (!RESETN)
      UNSUPPORTED_REQ |=> sts_bits[3];
  endproperty
  a_ur_set: assert property (p_ur_set)
    else $error("unsupported request not logged");

  property p_rep_fatal;
    @(posedge REF_CLK) disable iff (!RESETN)
      (FATAL_ERR && ctl_q[PDCS_FE_BIT]) |=> REPORT_FATAL;
  endproperty
  a_rep_fatal: assert property (p_rep_fatal)
    else $error("fatal error not reported");

  property p_rep_ce_gate;
    @(posedge REF_CLK) disable iff (!RESETN)
      !ctl_q[PDCS_CE_BIT] |=> !REPORT_CORRECTABLE;
  endproperty
  a_rep_ce_gate: assert property (p_rep_ce_gate)
    else $error("correctable reported while disabled");

  property p_mps_reserved;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] > 3'h4) |=> (MAX_PAYLOAD_BYTES == 12'h080);
  endproperty
  a_mps_reserved: assert property (p_mps_reserved)
    else $error("reserved payload code not 128 bytes");

  property p_mps_2048;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] == 3'h4) |=> (MAX_PAYLOAD_BYTES == 12'h800);
  endproperty
  a_mps_2048: assert property (p_mps_2048)
    else $error("payload code 4 not 2048 bytes");

  property p_sts_ro;
    @(posedge REF_CLK) disable iff (!RESETN)
      (REG_RD && hit_sts) |=> (REG_RDATA[15:4] == 12'h000);
  endproperty
  a_sts_ro: assert property (p_sts_ro)
    else $error("status upper bits not zero");

  property p_tag_short;
    @(posedge REF_CLK) disable iff (!RESETN)
      (dbg_q && !ctl_q[PDCS_ETAG_BIT] && $past(dbg_q)
        && !$past(ctl_q[PDCS_ETAG_BIT])) |-> (DEBUG_TAG <= 8'h1f);
  endproperty
  a_tag_short: assert property (p_tag_short)
    else $error("debug tag beyond 31");

  // logging never depends on the reporting enables
  property p_ce_clear;
    @(posedge REF_CLK) disable iff (!RESETN)
      (wr_sts && REG_WDATA[0] && !CORRECTABLE_ERR) |=> !sts_bits[0];
  endproperty
  a_ce_clear: assert property (p_ce_clear)
    else $error("correctable bit not cleared");

  property p_ce_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
      (sts_bits[0] && !(wr_sts && REG_WDATA[0])) |=> sts_bits[0];
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("correctable bit lost without clear");

  property p_nfe_set;
    @(posedge REF_CLK) disable iff (!RESETN)
      NONFATAL_ERR |=> sts_bits[1];
  endproperty
  a_nfe_set: assert property (p_nfe_set)
    else $error("non-fatal event not logged");

  property p_nfe_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
      (sts_bits[1] && !(wr_sts && REG_WDATA[1])) |=> sts_bits[1];
  endproperty
  a_nfe_hold: assert property (p_nfe_hold)
    else $error("non-fatal bit lost without clear");

  property p_fe_set;
    @(posedge REF_CLK) disable iff (!RESETN)
      FATAL_ERR |=> sts_bits[2];
  endproperty
  a_fe_set: assert property (p_fe_set)
    else $error("fatal event not logged");

  property p_fe_clear;
    @(posedge REF_CLK) disable iff (!RESETN)
      (wr_sts && REG_WDATA[2] && !FATAL_ERR) |=> !sts_bits[2];
  endproperty
  a_fe_clear: assert property (p_fe_clear)
    else $error("fatal bit not cleared");

  property p_ur_clear;
    @(posedge REF_CLK) disable iff (!RESETN)
      (wr_sts && REG_WDATA[3] && !UNSUPPORTED_REQ) |=> !sts_bits[3];
  endproperty
  a_ur_clear: assert property (p_ur_clear)
    else $error("unsupported request bit not cleared");

  property p_ur_hold;
    @(posedge REF_CLK) disable iff (!RESETN)
      (sts_bits[3] && !(wr_sts && REG_WDATA[3])) |=> sts_bits[3];
  endproperty
  a_ur_hold: assert property (p_ur_hold)
    else $error("unsupported request bit lost without clear");

  property p_rep_ce;
    @(posedge REF_CLK) disable iff (!RESETN)
      (CORRECTABLE_ERR && ctl_q[PDCS_CE_BIT]) |=> REPORT_CORRECTABLE;
  endproperty
  a_rep_ce: assert property (p_rep_ce)
    else $error("correctable error not reported");

  property p_rep_nfe;
    @(posedge REF_CLK) disable iff (!RESETN)
      (NONFATAL_ERR && ctl_q[PDCS_NFE_BIT]) |=> REPORT_NONFATAL;
  endproperty
  a_rep_nfe: assert property (p_rep_nfe)
    else $error("non-fatal error not reported");

  property p_rep_nfe_gate;
    @(posedge REF_CLK) disable iff (!RESETN)
      !ctl_q[PDCS_NFE_BIT] |=> !REPORT_NONFATAL;
  endproperty
  a_rep_nfe_gate: assert property (p_rep_nfe_gate)
    else $error("non-fatal reported while disabled");

  property p_rep_fe_gate;
    @(posedge REF_CLK) disable iff (!RESETN)
      !ctl_q[PDCS_FE_BIT] |=> !REPORT_FATAL;
  endproperty
  a_rep_fe_gate: assert property (p_rep_fe_gate)
    else $error("fatal reported while disabled");

  property p_rep_ur;
    @(posedge REF_CLK) disable iff (!RESETN)
      (UNSUPPORTED_REQ && ctl_q[PDCS_UR_BIT]) |=> REPORT_UNSUPPORTED_REQ;
  endproperty
  a_rep_ur: assert property (p_rep_ur)
    else $error("unsupported request not reported");

  property p_rep_ur_gate;
    @(posedge REF_CLK) disable iff (!RESETN)
      !ctl_q[PDCS_UR_BIT] |=> !REPORT_UNSUPPORTED_REQ;
  endproperty
  a_rep_ur_gate: assert property (p_rep_ur_gate)
    else $error("unsupported request reported while disabled");

  property p_mps_128;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] == 3'h0) |=> (MAX_PAYLOAD_BYTES == 12'h080);
  endproperty
  a_mps_128: assert property (p_mps_128)
    else $error("payload code 0 not 128 bytes");

  property p_mps_256;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] == 3'h1) |=> (MAX_PAYLOAD_BYTES == 12'h100);
  endproperty
  a_mps_256: assert property (p_mps_256)
    else $error("payload code 1 not 256 bytes");

  property p_mps_512;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] == 3'h2) |=> (MAX_PAYLOAD_BYTES == 12'h200);
  endproperty
  a_mps_512: assert property (p_mps_512)
    else $error("payload code 2 not 512 bytes");

  property p_mps_1024;
    @(posedge REF_CLK) disable iff (!RESETN)
      (ctl_q[7:5] == 3'h3) |=> (MAX_PAYLOAD_BYTES == 12'h400);
  endproperty
  a_mps_1024: assert property (p_mps_1024)
    else $error("payload code 3 not 1024 bytes");

  property p_tag_off;
    @(posedge REF_CLK) disable iff (!RESETN)
      !dbg_q |=> (DEBUG_TAG == 8'h00);
  endproperty
  a_tag_off: assert property (p_tag_off)
    else $error("debug tag not zero while disabled");
endmodule : pdcs_top
`default_nettype wire

// ===== verification/pdcs_bench.sv
// Purpose: self-checking bench for the device control and status bank
// Assumes: plain strobe register port, read data one cycle after strobe
// Notes: register names and offsets come from pdcs_pkg
`timescale 1ns/1ns
`default_nettype none
module pcie_device_control_status_bench
  import pdcs_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic adv = 1'b0;
  logic fwd_ns = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] err = 4'h0;
  logic [2:0] fsz = 3'h0;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [3:0] rep;
  logic [2:0] fsz_o;
  logic [11:0] mpb;
  logic ro;
  logic ns;
  logic ns_o;
  logic irq;
  logic [7:0] tag;
  int n_errors = 0;
  int n_tests = 0;

  pdcs_top u_dut (
    .REF_CLK(ref_clk), .RESETN(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CORRECTABLE_ERR(err[0]), .NONFATAL_ERR(err[1]),
    .FATAL_ERR(err[2]), .UNSUPPORTED_REQ(err[3]),
    .REPORT_CORRECTABLE(rep[0]), .REPORT_NONFATAL(rep[1]),
    .REPORT_FATAL(rep[2]), .REPORT_UNSUPPORTED_REQ(rep[3]),
    .MAX_PAYLOAD_BYTES(mpb), .RELAXED_ORDERING_CTL(ro),
    .NO_SNOOP_ENABLE(ns), .FWD_NO_SNOOP_IN(fwd_ns),
    .FWD_NO_SNOOP_OUT(ns_o), .FWD_RD_REQ_SIZE_IN(fsz),
    .FWD_RD_REQ_SIZE_OUT(fsz_o), .TAG_ADVANCE(adv), .DEBUG_TAG(tag),
    .IRQ(irq)
  );

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] seen);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // data are looked at only in the one cycle they stand
  task automatic rd_chk(input string what, input logic [7:0] a,
                        input logic [15:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    got = rdata;
    chk(what, exp, got);
  endtask : rd_chk

  task automatic pulse(input logic [3:0] e);
    @(posedge ref_clk);
    err <= e;
    @(posedge ref_clk);
    err <= 4'h0;
    #1;
  endtask : pulse

  task automatic tag_run(input int n);
    @(posedge ref_clk);
    adv <= 1'b1;
    repeat (n) @(posedge ref_clk);
    adv <= 1'b0;
    #1;
  endtask : tag_run

  // whole run is a few hundred cycles
  initial begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk("payload bytes", 16'h0080, {4'h0, mpb});
    rd_chk("control", PDCS_DEV_CTL_OFF,
           16'h0000);
    rd_chk("status", PDCS_DEV_STS_OFF,
           16'h0000);
    @(posedge ref_clk);
    #1;
    chk("read data idle", 16'h0000, rdata);
    $display("test reset done");
    wr_reg(PDCS_DEV_CTL_OFF, 16'hffff);
    rd_chk("control", PDCS_DEV_CTL_OFF,
           16'h01ef);
    chk("fixed controls", 16'h0000, {14'h0, ro, ns});
    wr_reg(PDCS_DEV_STS_OFF, 16'hffff);
    rd_chk("status", PDCS_DEV_STS_OFF, 16'h0000);
    wr_reg(8'h40, 16'hffff);
    rd_chk("unmapped", 8'h40, 16'h0000);
    @(posedge ref_clk);
    fwd_ns <= 1'b1;
    fsz <= 3'h5;
    @(posedge ref_clk);
    #1;
    chk("forwarded", 16'h000d, {12'h0, ns_o, fsz_o});
    $display("test access kinds done");
    for (int c = 0; c < 8; c++) begin
      wr_reg(PDCS_DEV_CTL_OFF, 16'(c) << 5);
      @(posedge ref_clk);
      #1;
      chk("payload bytes", (c < 5) ? 16'h0080 << c : 16'h0080,
          {4'h0, mpb});
    end
    $display("test payload done");
    // each event with its enable off, then on; masked so no irq
    for (int b = 0; b < 4; b++) begin
      for (int en = 0; en < 2; en++) begin
        wr_reg(PDCS_DEV_CTL_OFF, 16'(en) << b);
        pulse(4'(1) << b);
        chk("report", 16'(en) << b, {12'h0, rep});
        chk("irq masked", 16'h0000, {15'h0, irq});
        rd_chk("status set", PDCS_DEV_STS_OFF,
               16'h0001 << b);
        wr_reg(PDCS_DEV_STS_OFF, 16'h0001 << b);
        rd_chk("status clear", PDCS_DEV_STS_OFF,
               16'h0000);
      end
    end
    $display("test events done");
    wr_reg(PDCS_IRQ_MASK_OFF, 16'h000f);
    pulse(4'h4);
    chk("irq", 16'h0001, {15'h0, irq});
    wr_reg(PDCS_DEV_STS_OFF, 16'h0004);
    #1;
    chk("irq", 16'h0000, {15'h0, irq});
    wr_reg(PDCS_IRQ_MASK_OFF, 16'h000d);
    pulse(4'h2);
    chk("irq", 16'h0000, {15'h0, irq});
    // event beside a write-one clear: the event must stay logged
    @(posedge ref_clk);
    addr <= PDCS_DEV_STS_OFF;
    wdata <= 16'h0003;
    wr <= 1'b1;
    err <= 4'h1;
    @(posedge ref_clk);
    wr <= 1'b0;
    err <= 4'h0;
    rd_chk("status race", PDCS_DEV_STS_OFF, 16'h0001);
    wr_reg(PDCS_DEV_STS_OFF, 16'h0001);
    $display("test irq done");
    tag_run(4);
    chk("tag off", 16'h0000, {8'h0, tag});
    wr_reg(PDCS_DBG_CTL_OFF, 16'h0001);
    wr_reg(PDCS_DEV_CTL_OFF, 16'h0000);
    tag_run(33);
    chk("tag short", 16'h0001, {8'h0, tag});
    wr_reg(PDCS_DEV_CTL_OFF, 16'h0100);
    tag_run(254);
    chk("tag long", 16'h00ff, {8'h0, tag});
    tag_run(1);
    chk("tag wrap", 16'h0000, {8'h0, tag});
    $display("test debug tag done");
    end_sim();
  end
endmodule : pcie_device_control_status_bench
`default_nettype wire
